/* design/pfbs_pkg.sv */
// Purpose: constants for the power fault and boot status sequencer
// Assumes: 10 MHz core clock, 60 Hz line
// Notes:   error codes are held as four bcd digits
`default_nettype none
package pfbs_pkg;
    localparam int CLK_HZ        = 10_000_000;
    localparam int LINE_CYCLE_US = 16667;
    localparam int LINE_CYC      = (LINE_CYCLE_US * (CLK_HZ / 100_000) + 9) / 10;
    localparam int CHAR_TIME_MS  = 500;
    localparam int CHAR_CYC      = CHAR_TIME_MS * (CLK_HZ / 1000);
    localparam int BAR_TIME_MS   = 40;
    localparam int BAR_CYC       = BAR_TIME_MS * (CLK_HZ / 1000);
    localparam int NV_BYTES      = 32768;
    localparam logic [7:0]  A_CTRL  = 8'h00;
    localparam logic [7:0]  A_STAT  = 8'h04;
    localparam logic [7:0]  A_ERR   = 8'h08;
    localparam logic [7:0]  A_NVADR = 8'h0c;
    localparam logic [7:0]  A_NVDAT = 8'h10;
    localparam logic [0:0]  CTRL_RST = 1'h1;
    localparam logic [15:0] ERR_PF   = 16'h1999;
    localparam logic [15:0] ERR_WD   = 16'h1998;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [7:0]  CH_E     = 8'h45;
    localparam logic [7:0]  CH_F     = 8'h46;
    localparam logic [7:0]  CH_SP    = 8'h20;
    localparam logic [7:0]  CH_STAR  = 8'h2a;
    localparam logic [7:0]  CH_BAR   = 8'h7c;
    localparam logic [3:0]  CH_DIG   = 4'h3;
    typedef enum logic [2:0] {ST_DIAG, ST_INIT, ST_FLT, ST_LOAD, ST_RUN, ST_INTER} pfbs_state_t;
    typedef enum logic [1:0] {SRC_LAST, SRC_AUTO, SRC_OVR} pfbs_src_t;
endpackage
`default_nettype wire

/* design/pfbs_sequencer.sv */
// Purpose: boot source choice, power fault safe state, status display
// Assumes: firmware signals on core_clk; ac sense, button, supervisor are pins
// Notes:   display is one ascii character plus a bar column
//
// Local design decisions: the register offsets and the plain strobed port.
`default_nettype none
module pfbs_sequencer #(
    parameter int LINE_CYC_P = pfbs_pkg::LINE_CYC,
    parameter int CHAR_CYC_P = pfbs_pkg::CHAR_CYC,
    parameter int BAR_CYC_P  = pfbs_pkg::BAR_CYC,
    parameter int FAULT_W    = 32,
    parameter int IO_W       = 16,
    parameter int AXES       = 8
) (
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    input  wire logic                 ac_ok_pin,
    input  wire logic                 boot_select_button,
    input  wire logic                 cold_start_pin,
    input  wire logic                 supply_por_pin,
    input  wire logic                 diag_done,
    input  wire logic [7:0]           ver_char,
    input  wire logic                 ver_end,
    input  wire logic [FAULT_W-1:0]   fault_word,
    input  wire logic                 auto2_found,
    input  wire logic [1:0]           ovr_found,
    input  wire logic                 last_has_entry,
    input  wire logic                 load_done,
    input  wire logic                 interp_running,
    input  wire logic                 interp_err,
    input  wire logic [15:0]          err_code,
    input  wire logic                 stmt_ok,
    input  wire logic                 wdog_fault,
    input  wire logic                 nofault_req,
    input  wire logic [IO_W-1:0]      digital_io_point_req,
    input  wire logic [AXES-1:0]      axis_en_req,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata,
    output logic [5:0]                ver_idx,
    output logic                      load_req,
    output pfbs_pkg::pfbs_src_t       load_src,
    output logic [1:0]                load_slot,
    output logic                      run_allow,
    output logic [1:0]                card_led,
    output logic                      nofault_relay,
    output logic [IO_W-1:0]           digital_io_point,
    output logic [AXES-1:0]           axis_en,
    output logic                      wdog_led,
    output logic                      prog_stopped_led,
    output logic                      cpu_suspend,
    output logic [15:0]               err_out,
    output logic [7:0]                disp_char,
    output logic                      disp_bar_en,
    output logic [2:0]                disp_bar_col
);
    import pfbs_pkg::*;

    localparam int FB_W = $clog2(FAULT_W);

    // pin synchronisers, the first stage feeds only the second; reset age tells when straps have settled
    logic ac_s1, ac_s2, btn_s1, btn_s2, cold_s1, cold_s2, por_s1, por_s2;
    logic [1:0] rst_age_r;
    always_ff @(posedge core_clk) begin
        ac_s1   <= ac_ok_pin;
        ac_s2   <= ac_s1;
        btn_s1  <= boot_select_button;
        btn_s2  <= btn_s1;
        cold_s1 <= cold_start_pin;
        cold_s2 <= cold_s1;
        por_s1  <= supply_por_pin;
        por_s2  <= por_s1;
        rst_age_r <= nrst ? 2'b00 : {rst_age_r[0], 1'b1};
    end

    logic              pf_en_r;
    logic              pf_r;
    logic              pf_seen_r;
    logic [17:0]       ac_lo_cnt_r;
    logic [15:0]       err_r;
    logic              show_err_r;
    logic [14:0]       nv_adr_r;
    logic [7:0]        nv_mem [NV_BYTES];
    logic [22:0]       tick_cnt_r;
    logic              tick;
    logic              pulse_r;
    logic [2:0]        idx_r;
    logic [22:0]       bar_cnt_r;
    logic [22:0]       bar_lim_r;
    logic [7:0]        lfsr_r;
    logic              btn_held_r;
    logic [FB_W-1:0]   fbit_r;
    logic [1:0]        fph_r;
    pfbs_state_t       st_r;
    pfbs_src_t         src_nxt;
    logic [1:0]        slot_nxt;
    logic [7:0]        disp_nxt;
    logic              flt_last;

    // power sense: a half cycle dip never reaches the count
    always_ff @(posedge core_clk) begin
        if (!nrst || ac_s2 || !pf_en_r)
            ac_lo_cnt_r <= '0;
        else if (ac_lo_cnt_r != 18'(LINE_CYC_P))
            ac_lo_cnt_r <= ac_lo_cnt_r + 18'h1;
    end

    // latched until reset, so a returning line leaves the unit dead
    always_ff @(posedge core_clk) begin
        if (!nrst)
            pf_r <= 1'b0;
        else if (ac_lo_cnt_r == 18'(LINE_CYC_P - 1) && !ac_s2 && pf_en_r)
            pf_r <= 1'b1;
        pf_seen_r <= pf_r || (!nrst && pf_seen_r);
    end

    // error word lives through reset; straps count only once both sync stages hold reset-time values
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            if (rst_age_r[1] && cold_s2)
                err_r <= ERR_NONE;
            else if (rst_age_r[1] && pf_seen_r && !por_s2)
                err_r <= ERR_PF;
        end else if (interp_err)
            err_r <= err_code;
    end

    // error display sticks until a good statement; a new error wins
    always_ff @(posedge core_clk) begin
        if (!nrst)
            show_err_r <= 1'b0;
        else if (interp_err)
            show_err_r <= 1'b1;
        else if (stmt_ok)
            show_err_r <= 1'b0;
    end

    assign err_out = pf_r ? ERR_PF : err_r;
    // battery backed store: no reset, contents survive every reset
    always_ff @(posedge core_clk) begin
        if (reg_wr && reg_addr == A_NVDAT)
            nv_mem[nv_adr_r] <= reg_wdata[7:0];
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pf_en_r  <= CTRL_RST;
            nv_adr_r <= '0;
        end else if (reg_wr) begin
            if (reg_addr == A_CTRL)
                pf_en_r <= reg_wdata[0];
            if (reg_addr == A_NVADR)
                nv_adr_r <= reg_wdata[14:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst)
            reg_rdata <= '0;
        else if (reg_rd) begin
            unique case (reg_addr)
                A_CTRL:  reg_rdata <= {31'h0, pf_en_r};
                A_STAT:  reg_rdata <= {24'h0, btn_held_r, 2'(load_src), pf_r, 1'b0, 3'(st_r)};
                A_ERR:   reg_rdata <= {16'h0, err_out};
                A_NVADR: reg_rdata <= {17'h0, nv_adr_r};
                A_NVDAT: reg_rdata <= {24'h0, nv_mem[nv_adr_r]};
                default: reg_rdata <= '0;
            endcase
        end else
            reg_rdata <= '0;
    end

    // character rate tick; pulse toggles for blink and starburst
    assign tick = (tick_cnt_r == 23'(CHAR_CYC_P - 1));
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            tick_cnt_r <= '0;
            pulse_r    <= 1'b0;
            idx_r      <= '0;
        end else if (tick) begin
            tick_cnt_r <= '0;
            pulse_r    <= !pulse_r;
            idx_r      <= (idx_r == 3'h5) ? 3'h0 : idx_r + 3'h1;
        end else
            tick_cnt_r <= tick_cnt_r + 23'h1;
    end

    // bar step period doubles at random to look busy
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bar_cnt_r    <= '0;
            bar_lim_r    <= 23'(BAR_CYC_P - 1);
            lfsr_r       <= 8'h01;
            disp_bar_col <= '0;
        end else if (st_r == ST_DIAG && bar_cnt_r >= bar_lim_r) begin
            bar_cnt_r    <= '0;
            lfsr_r       <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
            bar_lim_r    <= lfsr_r[0] ? 23'(2 * BAR_CYC_P - 1) : 23'(BAR_CYC_P - 1);
            disp_bar_col <= (disp_bar_col == 3'h4) ? 3'h0 : disp_bar_col + 3'h1;
        end else
            bar_cnt_r <= bar_cnt_r + 23'h1;
    end

    // button is caught any time during diagnostics, sticky until reset
    always_ff @(posedge core_clk) begin
        if (!nrst)
            btn_held_r <= 1'b0;
        else if (st_r == ST_DIAG && btn_s2)
            btn_held_r <= 1'b1;
    end

    // boot source choice; the system card in slot 1 holds the last project
    always_comb begin
        src_nxt  = SRC_LAST;
        slot_nxt = 2'b01;
        if (btn_held_r) begin
            if (ovr_found[1]) begin
                src_nxt  = SRC_OVR;
                slot_nxt = 2'b10;
            end else if (ovr_found[0]) begin
                src_nxt  = SRC_OVR;
                slot_nxt = 2'b01;
            end
        end else if (auto2_found) begin
            src_nxt  = SRC_AUTO;
            slot_nxt = 2'b10;
        end
    end

    assign flt_last = (fbit_r == FB_W'(FAULT_W - 1));
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st_r      <= ST_DIAG;
            ver_idx   <= '0;
            fbit_r    <= '0;
            fph_r     <= '0;
            load_src  <= SRC_LAST;
            load_slot <= 2'b00;
            run_allow <= 1'b0;
        end else if (!pf_r) begin
            unique case (st_r)
                ST_DIAG:
                    if (diag_done)
                        st_r <= ST_INIT;
                ST_INIT:
                    if (ver_end)
                        st_r <= ST_FLT;
                    else if (tick)
                        ver_idx <= ver_idx + 6'h1;
                ST_FLT: begin
                    if (!fault_word[fbit_r] || (tick && fph_r == 2'h3)) begin
                        fph_r  <= '0;
                        fbit_r <= fbit_r + 1'b1;
                        if (flt_last) begin
                            st_r      <= ST_LOAD;
                            load_src  <= src_nxt;
                            load_slot <= slot_nxt;
                            run_allow <= !btn_held_r && (src_nxt == SRC_AUTO || last_has_entry);
                        end
                    end else if (tick)
                        fph_r <= fph_r + 2'h1;
                end
                ST_LOAD:
                    if (load_done) begin
                        load_slot <= 2'b00;
                        st_r <= run_allow ? ST_RUN : ST_INTER;
                    end
                ST_RUN, ST_INTER:
                    st_r <= interp_running ? ST_RUN : ST_INTER;
            endcase
        end
    end

    assign load_req = (st_r == ST_LOAD) && !pf_r;
    function automatic logic [7:0] msg_char(input logic [15:0] c, input logic [2:0] i);
        unique case (i)
            3'h0:    msg_char = CH_E;
            3'h1:    msg_char = {CH_DIG, c[15:12]};
            3'h2:    msg_char = {CH_DIG, c[11:8]};
            3'h3:    msg_char = {CH_DIG, c[7:4]};
            3'h4:    msg_char = {CH_DIG, c[3:0]};
            default: msg_char = CH_SP;
        endcase
    endfunction

    function automatic logic [7:0] flt_char(input logic [FB_W-1:0] b, input logic [1:0] p);
        logic [3:0] t;
        logic [3:0] o;
        t = (b >= 30) ? 4'h3 : (b >= 20) ? 4'h2 : (b >= 10) ? 4'h1 : 4'h0;
        o = 4'(b - FB_W'(t * 10));
        unique case (p)
            2'h0:    flt_char = CH_F;
            2'h1:    flt_char = {CH_DIG, t};
            2'h2:    flt_char = {CH_DIG, o};
            default: flt_char = CH_SP;
        endcase
    endfunction

    // fixed priority: power fault, watchdog, boot phase, mode
    always_comb begin
        disp_nxt = CH_SP;
        if (pf_r)
            disp_nxt = msg_char(ERR_PF, idx_r);
        else if (wdog_fault)
            disp_nxt = msg_char(ERR_WD, idx_r);
        else begin
            unique case (st_r)
                ST_DIAG:  disp_nxt = CH_BAR;
                ST_INIT:  disp_nxt = ver_char;
                ST_FLT:   disp_nxt = fault_word[fbit_r] ? flt_char(fbit_r, fph_r) : CH_SP;
                ST_LOAD:  disp_nxt = CH_SP;
                ST_RUN:   disp_nxt = CH_SP;
                ST_INTER: disp_nxt = show_err_r ? msg_char(err_r, idx_r) : (pulse_r ? CH_STAR : CH_SP);
            endcase
        end
    end

    // safe state registered one edge after the fault latches
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            disp_char        <= CH_SP;
            disp_bar_en      <= 1'b0;
            nofault_relay    <= 1'b0;
            digital_io_point <= '0;
            axis_en          <= '0;
            wdog_led         <= 1'b0;
            prog_stopped_led <= 1'b1;
            cpu_suspend      <= 1'b0;
            card_led         <= 2'b00;
        end else begin
            disp_char        <= disp_nxt;
            disp_bar_en      <= !pf_r && !wdog_fault && st_r == ST_DIAG;
            nofault_relay    <= nofault_req && !pf_r && !wdog_fault;
            digital_io_point <= (pf_r || wdog_fault) ? '0 : digital_io_point_req;
            axis_en          <= pf_r ? '0 : axis_en_req;
            wdog_led         <= !pf_r && !wdog_fault && st_r != ST_DIAG && pulse_r;
            prog_stopped_led <= st_r != ST_RUN;
            cpu_suspend      <= pf_r;
            card_led         <= (st_r == ST_LOAD && !pf_r && pulse_r) ? load_slot : 2'b00;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_pf_count;
        !pf_r && !ac_s2 && pf_en_r && ac_lo_cnt_r == 18'(LINE_CYC_P - 1) |=> pf_r;
    endproperty
    a_pf_count: assert property (p_pf_count) else $error("power fault not declared after one line cycle");
    property p_pf_cause;
        $rose(pf_r) |-> $past(ac_lo_cnt_r) == 18'(LINE_CYC_P - 1) && !$past(ac_s2);
    endproperty
    a_pf_cause: assert property (p_pf_cause) else $error("power fault declared too early");
    property p_pf_outs;
        pf_r |=> !nofault_relay && digital_io_point == '0;
    endproperty
    a_pf_outs: assert property (p_pf_outs) else $error("outputs or relay still on in power fault");
    property p_pf_axis;
        pf_r |=> axis_en == '0;
    endproperty
    a_pf_axis: assert property (p_pf_axis) else $error("axis enable on in power fault");
    property p_pf_disp;
        pf_r ##1 pf_r |-> !wdog_led && (disp_char == CH_E || disp_char == 8'h31 || disp_char == 8'h39
            || disp_char == CH_SP);
    endproperty
    a_pf_disp: assert property (p_pf_disp) else $error("power fault display or light wrong");
    property p_pf_hold;
        pf_r |=> pf_r && cpu_suspend && err_out == ERR_PF;
    endproperty
    a_pf_hold: assert property (p_pf_hold) else $error("power fault did not hold the processor");
    property p_wd_disp;
        !pf_r && wdog_fault ##1 !pf_r |-> disp_char != CH_STAR && disp_char != CH_BAR;
    endproperty
    a_wd_disp: assert property (p_wd_disp) else $error("watchdog code not shown");
    property p_run_blank;
        !pf_r && !wdog_fault && st_r == ST_RUN |=> disp_char == CH_SP && !prog_stopped_led;
    endproperty
    a_run_blank: assert property (p_run_blank) else $error("running display not blank");
    property p_auto;
        !pf_r && st_r == ST_FLT && $past(st_r) == ST_FLT ##1 st_r == ST_LOAD && !btn_held_r && auto2_found
            |-> load_src == SRC_AUTO && load_slot == 2'b10;
    endproperty
    a_auto: assert property (p_auto) else $error("auto-start project not chosen from slot 2");
    property p_ovr;
        $rose(st_r == ST_LOAD) && btn_held_r && $past(ovr_found[1]) |-> load_src == SRC_OVR && load_slot == 2'b10;
    endproperty
    a_ovr: assert property (p_ovr) else $error("override project order wrong");
    property p_btn_inter;
        $rose(st_r == ST_LOAD) && btn_held_r |-> !run_allow;
    endproperty
    a_btn_inter: assert property (p_btn_inter) else $error("button load allowed execution");
    c_pf:    cover property (!pf_r ##1 pf_r);
    c_btn:   cover property (btn_held_r && st_r == ST_LOAD ##[1:20] st_r == ST_INTER);
    c_flt:   cover property (st_r == ST_FLT && fault_word[fbit_r] && fph_r == 2'h2);
    c_run:   cover property (st_r == ST_LOAD ##1 st_r == ST_RUN);
endmodule
`default_nettype wire

/* dv/pfbs_card_model.sv */
// Purpose: card slots and version text facing the sequencer
// Assumes: load_done is a level held until load_req drops
// Notes:   load latency is redrawn for each load, so loads run prompt or slow
`default_nettype none
module pfbs_card_model (
    input  wire logic       core_clk,
    input  wire logic       load_req,
    input  wire logic [5:0] ver_idx,
    output var logic        load_done,
    output logic [7:0]      ver_char,
    output logic            ver_end
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [39:0] TXT = 40'h4d42312e30;
    int cnt = 0;
    int lat = 8;
    initial load_done = 1'b0;
    // slot 1 always holds the system card, so every load request is served
    always @(posedge core_clk) begin
        cnt <= load_req ? cnt + 1 : 0;
        lat <= load_req ? lat : 8 + $urandom % 12;
        load_done <= load_req && cnt >= lat;
    end
    assign ver_end  = ver_idx > 6'h4;
    assign ver_char = ver_end ? 8'h20 : TXT[8 * (4 - int'(ver_idx)) +: 8];
endmodule
`default_nettype wire

/* dv/pfbs_sequencer_test.sv */
// Purpose: self-checking bench for the power fault and boot sequencer
// Assumes: short line, character and bar counts
// Notes:   the bench plays firmware, pins and straps; cards come from the model
`default_nettype none
module pfbs_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    import pfbs_pkg::*;
    localparam int LC = 20;
    localparam int CC = 4;
    localparam int BC = 3;
    logic        core_clk = '0, nrst = '0, ac_ok_pin = '1, boot_select_button = '0, cold_start_pin = '1;
    logic        supply_por_pin = '0, diag_done = '0, auto2_found = '0, last_has_entry = '0, stmt_ok = '0;
    logic        interp_running = '0, interp_err = '0, wdog_fault = '0, nofault_req = '0, reg_wr = '0, reg_rd = '0;
    logic        ver_end, load_done, load_req, run_allow, nofault_relay, wdog_led, prog_stopped_led;
    logic        cpu_suspend, disp_bar_en;
    logic [1:0]  ovr_found = '0, load_slot, card_led;
    logic [31:0] fault_word = '0, reg_wdata = '0, reg_rdata, d, r;
    logic [15:0] err_code = '0, digital_io_point_req = '0, digital_io_point, err_out;
    logic [7:0]  axis_en_req = '0, reg_addr = '0, ver_char, axis_en, disp_char;
    logic [5:0]  ver_idx;
    logic [2:0]  disp_bar_col;
    pfbs_src_t   load_src;
    int          failures = 0, checks_done = 0, n;
    pfbs_sequencer #(.LINE_CYC_P(LC), .CHAR_CYC_P(CC), .BAR_CYC_P(BC)) uut (.core_clk, .nrst, .ac_ok_pin,
        .boot_select_button, .cold_start_pin, .supply_por_pin, .diag_done, .ver_char, .ver_end, .fault_word,
        .auto2_found, .ovr_found, .last_has_entry, .load_done, .interp_running, .interp_err, .err_code, .stmt_ok,
        .wdog_fault, .nofault_req, .digital_io_point_req, .axis_en_req, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .ver_idx, .load_req, .load_src, .load_slot, .run_allow, .card_led, .nofault_relay,
        .digital_io_point, .axis_en, .wdog_led, .prog_stopped_led, .cpu_suspend, .err_out, .disp_char,
        .disp_bar_en, .disp_bar_col);
    pfbs_card_model cards (.core_clk, .load_req, .ver_idx, .load_done, .ver_char, .ver_end);
    always #50 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    // stops at the first hit when a hit is expected, so that ordered waits follow the display
    task automatic see(input logic [7:0] ch, input int lim, input logic exp);
        logic hit;
        hit = 0;
        repeat (lim) begin
            @(negedge core_clk);
            hit |= disp_char === ch;
            if (hit && exp)
                break;
        end
        chk(hit, exp);
    endtask
    task automatic wait_lvl(ref logic s, input logic lvl);
        n = 0;
        while (s !== lvl && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
    endtask
    // read data are taken in the one cycle after the strobe
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= wd;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge core_clk);
        reg_wr <= 0;
        reg_rd <= 0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    // straps must cross the pin synchronisers while reset is still low
    task automatic do_reset(input logic cold, input logic por);
        @(posedge core_clk);
        nrst <= 0;
        cold_start_pin <= cold;
        supply_por_pin <= por;
        interp_running <= 0;
        tick(3);
        nrst <= 1;
        @(negedge core_clk);
    endtask
    function automatic pfbs_src_t exp_src(input logic btn, input logic aut, input logic [1:0] ovr);
        if (btn)
            return ovr != 2'h0 ? SRC_OVR : SRC_LAST;
        return aut ? SRC_AUTO : SRC_LAST;
    endfunction
    task automatic boot(input logic btn, input logic aut, input logic [1:0] ovr, input logic ent, input int fb);
        pfbs_src_t  src;
        logic [1:0] slot;
        logic       lit;
        logic       runs;
        src = exp_src(btn, aut, ovr);
        slot = (src == SRC_AUTO || (src == SRC_OVR && ovr[1])) ? 2'h2 : 2'h1;
        runs = !btn && (aut || ent);
        lit = 0;
        @(posedge core_clk);
        boot_select_button <= btn;
        auto2_found <= aut;
        ovr_found <= ovr;
        last_has_entry <= ent;
        wdog_fault <= 0;
        fault_word <= fb < 0 ? 32'h0 : 32'h1 << fb;
        do_reset(0, 0);
        tick(BC * 4);
        #1;
        chk(disp_bar_en, 1);
        chk(disp_bar_col <= 3'h4, 1);
        @(posedge core_clk);
        diag_done <= 1;
        @(posedge core_clk);
        diag_done <= 0;
        boot_select_button <= 0;
        see(8'h4d, 40, 1);
        see(8'h42, 20, 1);
        if (fb >= 0) begin
            see(CH_F, 200, 1);
            see(8'h30 + 8'(fb % 10), 16, 1);
        end
        wait_lvl(load_req, 1);
        chk(load_src, src);
        chk(load_slot, slot);
        repeat (8) begin
            @(negedge core_clk);
            lit |= card_led === slot;
        end
        chk(lit, 1);
        wait_lvl(load_req, 0);
        tick(2);
        #1;
        chk(run_allow, runs);
        if (runs) begin
            @(posedge core_clk);
            interp_running <= 1;
            tick(CC * 2);
            #1;
            chk(disp_char, CH_SP);
            chk(prog_stopped_led, 0);
        end else begin
            see(CH_STAR, 40, 1);
            chk(prog_stopped_led, 1);
        end
    endtask
    initial begin
        #3_000_000;
        failures++;
        final_report();
    end
    initial begin
        r = $urandom(89);
        do_reset(1, 0);
        chk(prog_stopped_led, 1);
        chk(err_out, ERR_NONE);
        bus(0, A_CTRL, 0);
        chk(d, 32'h1);
        bus(0, 8'h14, 0);
        chk(d, 32'h0);
        bus(1, A_NVADR, 32'h7fff);
        bus(1, A_NVDAT, 32'ha5);
        boot(0, 1, 2'h0, 0, -1);
        boot(1, 1, 2'h3, 0, 5);
        boot(1, 0, 2'h1, 1, 31);
        boot(1, 0, 2'h0, 1, -1);
        boot(0, 0, 2'h0, 1, 10);
        boot(0, 0, 2'h0, 0, 0);
        repeat (3) begin
            r = $urandom;
            boot(r[0], r[1], r[3:2], r[4], r[9] ? int'(r[14:10]) : -1);
        end
        // the address register clears on reset, the store itself must not
        bus(1, A_NVADR, 32'h7fff);
        bus(0, A_NVDAT, 0);
        chk(d, 32'ha5);
        boot(0, 1, 2'h0, 0, -1);
        @(posedge core_clk);
        wdog_fault <= 1;
        see(CH_E, 40, 1);
        see(8'h38, 24, 1);
        boot(1, 0, 2'h0, 0, -1);
        r = $urandom;
        @(posedge core_clk);
        interp_err <= 1;
        err_code <= 16'h0042;
        nofault_req <= 1;
        digital_io_point_req <= r[15:0] | 16'h1;
        axis_en_req <= 8'hff;
        @(posedge core_clk);
        interp_err <= 0;
        see(CH_E, 40, 1);
        @(posedge core_clk);
        stmt_ok <= 1;
        @(posedge core_clk);
        stmt_ok <= 0;
        see(CH_STAR, 40, 1);
        @(posedge core_clk);
        ac_ok_pin <= 0;
        tick(LC / 2);
        ac_ok_pin <= 1;
        tick(LC + 8);
        #1;
        chk(cpu_suspend, 0);
        chk(digital_io_point, digital_io_point_req);
        chk(nofault_relay, 1);
        @(posedge core_clk);
        ac_ok_pin <= 0;
        wdog_fault <= 1;
        wait_lvl(cpu_suspend, 1);
        chk(n >= LC && n <= LC + 5, 1);
        chk(nofault_relay, 0);
        chk(digital_io_point, 0);
        chk(axis_en, 0);
        chk(wdog_led, 0);
        chk(err_out, ERR_PF);
        see(CH_E, 40, 1);
        see(8'h39, 12, 1);
        see(8'h38, 48, 0);
        @(posedge core_clk);
        ac_ok_pin <= 1;
        wdog_fault <= 0;
        tick(LC + 10);
        bus(0, A_ERR, 0);
        chk(d, 32'h1999);
        chk(cpu_suspend, 1);
        do_reset(0, 1);
        chk(err_out, 16'h0042);
        @(posedge core_clk);
        ac_ok_pin <= 0;
        wait_lvl(cpu_suspend, 1);
        @(posedge core_clk);
        ac_ok_pin <= 1;
        do_reset(0, 0);
        chk(err_out, ERR_PF);
        chk(cpu_suspend, 0);
        do_reset(1, 0);
        chk(err_out, ERR_NONE);
        final_report();
    end
endmodule
`default_nettype wire
